// File: design/psdo_pkg.sv
// Operation
// RULE1 - A pin is an output when its direction bit is one and an input when zero, unless overridden.
// RULE2 - Peripheral overrides never change the stored direction bit, so reads return what software wrote.
// RULE3 - On pin 2 the enabled clock output forces the pin to output.
// RULE4 - On pin 2 the enabled synchronous serial peripheral forces input or output per its own setting.
// RULE5 - On pin 2 the routed first serial interface forces the pin to input when enabled.
// RULE6 - On pin 2 the routed PWM channel forces the pin to output when enabled.
// RULE7 - On pin 2 the routed external trigger leaves the pin direction alone.
// RULE8 - On pins 1 and 0 the enabled async serial unit forces each pin per its own setting.
// RULE9 - On pin 1 the routed LIN transceiver forces output, driving the LIN transmit drive bit.
// RULE10 - Competing overrides resolve by a fixed priority; the direction bit applies only without one.
package psdo_pkg;
  localparam int          PSDO_DATA_W     = 32;
  localparam int          PSDO_ADDR_W     = 4;
  localparam int          PSDO_PORT_W     = 8;
  localparam logic [3:0]  PSDO_OFS_DIR    = 4'h0;
  localparam logic [3:0]  PSDO_OFS_OUT    = 4'h4;
  localparam logic [3:0]  PSDO_OFS_CTRL   = 4'h8;
  localparam logic [3:0]  PSDO_OFS_STAT   = 4'hC;
  localparam logic [7:0]  PSDO_DIR_RST    = 8'h00;
  localparam logic [7:0]  PSDO_OUT_RST    = 8'h00;
  localparam logic [1:0]  PSDO_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  PSDO_RESP_SLVERR = 2'h2;
  // control register fields
  localparam int          PSDO_CTL_CLKOUT = 0;
  localparam int          PSDO_CTL_SPI_EN = 1;
  localparam int          PSDO_CTL_SPI_OE = 2;
  localparam int          PSDO_CTL_SIF1   = 3;
  localparam int          PSDO_CTL_PWM    = 4;
  localparam int          PSDO_CTL_XTRIG  = 5;
  localparam int          PSDO_CTL_ASU_EN = 6;
  localparam int          PSDO_CTL_ASU_O1 = 7;
  localparam int          PSDO_CTL_ASU_O0 = 8;
  localparam int          PSDO_CTL_LIN    = 9;
  localparam int          PSDO_CTL_LINDRV = 10;
  localparam int          PSDO_CTL_W      = 11;
  localparam logic [10:0] PSDO_CTL_RST    = 11'h000;

  typedef struct packed {
    logic [PSDO_PORT_W-1:0] oe;
    logic [PSDO_PORT_W-1:0] dout;
  } psdo_pin_type;
endpackage : psdo_pkg

// File: design/psdo_resolve.sv
`timescale 1ns/1ns
module psdo_resolve
  import psdo_pkg::*;
(
  // software state
  input  wire logic [PSDO_PORT_W-1:0] dir_bits,
  input  wire logic [PSDO_PORT_W-1:0] out_bits,
  input  wire logic [PSDO_CTL_W-1:0]  ctrl,
  // peripheral drive values
  input  wire logic                   clk_out_val,
  input  wire logic                   spi_out_val,
  input  wire logic                   pwm_out_val,
  input  wire logic [1:0]             asu_out_val,
  // resolved pin state
  output psdo_pin_type                pins
);
  always_comb
  begin
    pins.oe   = dir_bits; // RULE1
    pins.dout = out_bits;
    // pin 2, highest priority first
    if (ctrl[PSDO_CTL_CLKOUT]) // RULE10
    begin
      pins.oe[2]   = 1'b1; // RULE3
      pins.dout[2] = clk_out_val;
    end
    else if (ctrl[PSDO_CTL_SPI_EN])
    begin
      pins.oe[2]   = ctrl[PSDO_CTL_SPI_OE]; // RULE4
      pins.dout[2] = spi_out_val;
    end
    else if (ctrl[PSDO_CTL_SIF1])
    begin
      pins.oe[2]   = 1'b0; // RULE5
      pins.dout[2] = 1'b0;
    end
    else if (ctrl[PSDO_CTL_PWM])
    begin
      pins.oe[2]   = 1'b1; // RULE6
      pins.dout[2] = pwm_out_val;
    end
    // trigger routing touches nothing RULE7
    // pin 1
    if (ctrl[PSDO_CTL_ASU_EN]) // RULE10
    begin
      pins.oe[1]   = ctrl[PSDO_CTL_ASU_O1]; // RULE8
      pins.dout[1] = asu_out_val[1];
    end
    else if (ctrl[PSDO_CTL_LIN])
    begin
      pins.oe[1]   = 1'b1; // RULE9
      pins.dout[1] = ctrl[PSDO_CTL_LINDRV];
    end
    // pin 0
    if (ctrl[PSDO_CTL_ASU_EN])
    begin
      pins.oe[0]   = ctrl[PSDO_CTL_ASU_O0]; // RULE8
      pins.dout[0] = asu_out_val[0];
    end
  end
endmodule : psdo_resolve

// File: design/psdo_top.sv
`timescale 1ns/1ns
module psdo_top
  import psdo_pkg::*;
#(
  parameter int PORT_W = PSDO_PORT_W
)
(
  // clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   RST_B,
  // axi4-lite write address
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [PSDO_ADDR_W-1:0] S_AXI_AWADDR,
  // axi4-lite write data
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  input  wire logic [PSDO_DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  // axi4-lite write response
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  output logic [1:0]                  S_AXI_BRESP,
  // axi4-lite read
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  input  wire logic [PSDO_ADDR_W-1:0] S_AXI_ARADDR,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  output logic [PSDO_DATA_W-1:0]      S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  // peripheral drive values
  input  wire logic                   CLK_OUT_VAL,
  input  wire logic                   SPI_OUT_VAL,
  input  wire logic                   PWM_OUT_VAL,
  input  wire logic [1:0]             ASU_OUT_VAL,
  // port pins
  input  wire logic [PORT_W-1:0]      PIN_IN,
  output logic [PORT_W-1:0]           PIN_OUT,
  output logic [PORT_W-1:0]           PIN_OE_B,
  // received level to peripherals
  output logic [PORT_W-1:0]           PIN_LEVEL
);
  // only the documented port width is served
  if (PORT_W != PSDO_PORT_W)
  begin : g_port_w_chk
    $error("psdo_top: PORT_W must equal 8");
  end

  logic [PORT_W-1:0]       dir_r, dir_nxt, out_r, out_nxt;
  logic [PSDO_CTL_W-1:0]   ctrl_r, ctrl_nxt;
  logic                    aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt;
  logic [PSDO_ADDR_W-1:0]  awa_r, awa_nxt;
  logic [PSDO_DATA_W-1:0]  wd_r, wd_nxt;
  logic [3:0]              ws_r, ws_nxt;
  logic [1:0]              bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic                    rv_r, rv_nxt;
  logic [PSDO_DATA_W-1:0]  rd_r, rd_nxt;
  logic                    awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, ardy_r, ardy_nxt;
  logic [PORT_W-1:0]       pout_r, poe_r, plev_r;
  psdo_pin_type            pins;

  function automatic logic [PSDO_DATA_W-1:0] mergew(input logic [PSDO_DATA_W-1:0] old,
                                                   input logic [PSDO_DATA_W-1:0] dat,
                                                   input logic [3:0] st);
    logic [PSDO_DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = dat[i*8 +: 8];
    return r;
  endfunction : mergew

  psdo_resolve u_resolve
  (
    .dir_bits    (dir_r),
    .out_bits    (out_r),
    .ctrl        (ctrl_r),
    .clk_out_val (CLK_OUT_VAL),
    .spi_out_val (SPI_OUT_VAL),
    .pwm_out_val (PWM_OUT_VAL),
    .asu_out_val (ASU_OUT_VAL),
    .pins        (pins)
  );

  // write channel and register update
  always_comb
  begin
    logic [PSDO_DATA_W-1:0] m;
    m         = '0;
    aw_nxt    = aw_r;
    w_nxt     = w_r;
    awa_nxt   = awa_r;
    wd_nxt    = wd_r;
    ws_nxt    = ws_r;
    bv_nxt    = bv_r;
    bresp_nxt = bresp_r;
    dir_nxt   = dir_r;
    out_nxt   = out_r;
    ctrl_nxt  = ctrl_r;
    if (S_AXI_AWVALID && !aw_r && !bv_r)
    begin
      aw_nxt  = 1'b1;
      awa_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_r && !bv_r)
    begin
      w_nxt  = 1'b1;
      wd_nxt = S_AXI_WDATA;
      ws_nxt = S_AXI_WSTRB;
    end
    if (aw_r && w_r)
    begin
      aw_nxt    = 1'b0;
      w_nxt     = 1'b0;
      bv_nxt    = 1'b1;
      bresp_nxt = PSDO_RESP_OKAY;
      if (awa_r == PSDO_OFS_DIR)
      begin
        m       = mergew({24'h0, dir_r}, wd_r, ws_r);
        dir_nxt = m[PORT_W-1:0]; // RULE2
      end
      else if (awa_r == PSDO_OFS_OUT)
      begin
        m       = mergew({24'h0, out_r}, wd_r, ws_r);
        out_nxt = m[PORT_W-1:0];
      end
      else if (awa_r == PSDO_OFS_CTRL)
      begin
        m        = mergew({21'h0, ctrl_r}, wd_r, ws_r);
        ctrl_nxt = m[PSDO_CTL_W-1:0];
      end
      else if (awa_r != PSDO_OFS_STAT)
        bresp_nxt = PSDO_RESP_SLVERR;
    end
    if (bv_r && S_AXI_BREADY)
      bv_nxt = 1'b0;
    // readies registered so the ports come from flops
    awrdy_nxt = ~aw_nxt & ~bv_nxt;
    wrdy_nxt  = ~w_nxt & ~bv_nxt;
  end

  // read channel
  always_comb
  begin
    rv_nxt    = rv_r;
    rd_nxt    = rd_r;
    rresp_nxt = rresp_r;
    if (rv_r && S_AXI_RREADY)
      rv_nxt = 1'b0;
    else if (!rv_r && S_AXI_ARVALID)
    begin
      rv_nxt    = 1'b1;
      rresp_nxt = PSDO_RESP_OKAY;
      if (S_AXI_ARADDR == PSDO_OFS_DIR)
        rd_nxt = {24'h0, dir_r}; // RULE2
      else if (S_AXI_ARADDR == PSDO_OFS_OUT)
        rd_nxt = {24'h0, out_r};
      else if (S_AXI_ARADDR == PSDO_OFS_CTRL)
        rd_nxt = {21'h0, ctrl_r};
      else if (S_AXI_ARADDR == PSDO_OFS_STAT)
        rd_nxt = {8'h0, plev_r, pout_r, ~poe_r};
      else
      begin
        rd_nxt    = '0;
        rresp_nxt = PSDO_RESP_SLVERR;
      end
    end
    ardy_nxt = ~rv_nxt;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      aw_r    <= 1'b0;
      w_r     <= 1'b0;
      awa_r   <= '0;
      wd_r    <= '0;
      ws_r    <= '0;
      bv_r    <= 1'b0;
      bresp_r <= PSDO_RESP_OKAY;
      dir_r   <= PSDO_DIR_RST;
      out_r   <= PSDO_OUT_RST;
      ctrl_r  <= PSDO_CTL_RST;
      rv_r    <= 1'b0;
      rd_r    <= '0;
      rresp_r <= PSDO_RESP_OKAY;
      awrdy_r <= 1'b1;
      wrdy_r  <= 1'b1;
      ardy_r  <= 1'b1;
      pout_r  <= '0;
      poe_r   <= '1;
      plev_r  <= '0;
    end
    else
    begin
      aw_r    <= aw_nxt;
      w_r     <= w_nxt;
      awa_r   <= awa_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      bv_r    <= bv_nxt;
      bresp_r <= bresp_nxt;
      dir_r   <= dir_nxt;
      out_r   <= out_nxt;
      ctrl_r  <= ctrl_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      rresp_r <= rresp_nxt;
      awrdy_r <= awrdy_nxt;
      wrdy_r  <= wrdy_nxt;
      ardy_r  <= ardy_nxt;
      pout_r  <= pins.dout;
      poe_r   <= ~pins.oe; // RULE1
      plev_r  <= PIN_IN;
    end
  end

  assign S_AXI_AWREADY = awrdy_r;
  assign S_AXI_WREADY  = wrdy_r;
  assign S_AXI_BVALID  = bv_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = ardy_r;
  assign S_AXI_RVALID  = rv_r;
  assign S_AXI_RDATA   = rd_r;
  assign S_AXI_RRESP   = rresp_r;
  assign PIN_OUT       = pout_r;
  assign PIN_OE_B      = poe_r;
  assign PIN_LEVEL     = plev_r;
endmodule : psdo_top

// File: tb/psdo_props.sv
`timescale 1ns/1ns
module psdo_props
  import psdo_pkg::*;
#(parameter int PORT_W = 8)
(
  // clock and reset
  input logic REF_CLK,
  input logic RST_B,
  // bus
  input logic S_AXI_AWVALID,
  input logic S_AXI_AWREADY,
  input logic S_AXI_WVALID,
  input logic S_AXI_WREADY,
  input logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic [1:0] S_AXI_BRESP,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  input logic [PSDO_DATA_W-1:0] S_AXI_RDATA,
  // pins
  input logic [PORT_W-1:0] PIN_IN,
  input logic [PORT_W-1:0] PIN_OUT,
  input logic [PORT_W-1:0] PIN_OE_B,
  input logic [PORT_W-1:0] PIN_LEVEL
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  property p_rst; $rose(RST_B) |-> PIN_OE_B == '1 && PIN_OUT == '0; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_lvl; $past(RST_B) |-> PIN_LEVEL == $past(PIN_IN); endproperty
  a_lvl: assert property (p_lvl) else $error("pin level lag wrong");
  property p_blat;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_rlat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_arb; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_arb: assert property (p_arb) else $error("read taken while busy");
endmodule : psdo_props
bind psdo_top psdo_props #(.PORT_W(PORT_W)) u_props (.*);

// File: tb/psdo_board.sv
`timescale 1ns/1ns
module psdo_board #(parameter int PORT_W = 8)
(
  // clock
  input logic clk,
  // pins
  input logic [PORT_W-1:0] pin_out,
  input logic [PORT_W-1:0] pin_oe_b,
  output logic [PORT_W-1:0] pin_in
);
  logic [PORT_W-1:0] pat_r = '0;
  // undriven pins see a toggling level
  always_ff @(posedge clk) pat_r <= ~pat_r;
  assign pin_in = (pin_out & ~pin_oe_b) | (pat_r & pin_oe_b);
endmodule : psdo_board

// File: tb/psdo_top_tb.sv
`timescale 1ns/1ns
module psdo_top_tb
  import psdo_pkg::*;
;
  logic clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic ck = 0, sp = 0, pw = 0, awr, wrdy, bv, arr, rv;
  logic [1:0] sc = 0, br, rr, eb, qb[$];
  logic [3:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, s = 32'h2C5F, rdat, r;
  logic [7:0] pin_in, pin_out, oe_b, d, o;
  logic [10:0] c;
  logic [15:0] x;
  logic [65:0] e, q[$];
  int num_errors = 0, comparisons = 0, cyc = 0;
  always #20 clk = ~clk;
  psdo_top u_dut (.REF_CLK(clk), .RST_B(rst_b), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .CLK_OUT_VAL(ck),
    .SPI_OUT_VAL(sp), .PWM_OUT_VAL(pw), .ASU_OUT_VAL(sc), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_B(oe_b), .PIN_LEVEL());
  psdo_board u_board (.clk(clk), .pin_out(pin_out), .pin_oe_b(oe_b), .pin_in(pin_in));
  function logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  // expected {out, oe}
  function logic [15:0] mdl(input logic [7:0] dd, oo, input logic [10:0] cc);
    logic [7:0] en, v;
    en = dd;
    v = dd & oo;
    if (cc[6]) {en[1:0], v[1:0]} = {cc[7], cc[8], cc[7] & sc[1], cc[8] & sc[0]};
    else if (cc[9]) {en[1], v[1]} = {1'b1, cc[10]};
    if (cc[0]) {en[2], v[2]} = {1'b1, ck};
    else if (cc[1]) {en[2], v[2]} = {cc[2], cc[2] & sp};
    else if (cc[3]) {en[2], v[2]} = 2'b00;
    else if (cc[4]) {en[2], v[2]} = {1'b1, pw};
    return {v, en};
  endfunction : mdl
  task wr_reg(input logic [3:0] a, input logic [31:0] dat,
              input logic [1:0] rsp = PSDO_RESP_OKAY);
    qb.push_back(rsp);
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= dat;
    bre <= 1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end
    while (bv !== 1'b1);
    bre <= 0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [31:0] ex, m,
              input logic [1:0] rsp = PSDO_RESP_OKAY);
    q.push_back({rsp, m, ex});
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rre <= 1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 0;
    end
    while (rv !== 1'b1);
    rre <= 0;
  endtask : rd_reg
  task conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // result watcher
  always @(posedge clk)
  begin
    cyc++;
    if (rv === 1'b1 && rre === 1'b1)
    begin
      e = q.pop_front();
      comparisons++;
      if ((rdat & e[63:32]) !== e[31:0] || rr !== e[65:64])
      begin
        $display("[ERR] %0t read %h resp %h expected %h", $time, rdat, rr, e[31:0]);
        num_errors++;
      end
    end
    if (bv === 1'b1 && bre === 1'b1)
    begin
      eb = qb.pop_front();
      comparisons++;
      if (br !== eb)
      begin
        $display("[ERR] %0t write response %h expected %h", $time, br, eb);
        num_errors++;
      end
    end
    if (cyc == 20000)
    begin
      $display("[ERR] %0t timeout", $time);
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    rd_reg(PSDO_OFS_DIR, 32'h0, 32'hFFFFFFFF);
    rd_reg(PSDO_OFS_STAT, 32'h0, 32'hFF00FFFF);
    for (int i = 0; i < 80; i++)
    begin
      r = xs();
      d = r[7:0];
      o = r[15:8];
      c = r[26:16];
      r = xs();
      ck <= r[0];
      sp <= r[1];
      pw <= r[2];
      sc <= r[4:3];
      wr_reg(PSDO_OFS_DIR, {24'h0, d});
      wr_reg(PSDO_OFS_OUT, {24'h0, o});
      wr_reg(PSDO_OFS_CTRL, {21'h0, c});
      rd_reg(PSDO_OFS_DIR, {24'h0, d}, 32'hFFFFFFFF);
      x = mdl(d, o, c);
      rd_reg(PSDO_OFS_STAT, {16'h0, x}, {16'hFF00, x[7:0], 8'hFF});
    end
    // read-only and unmapped offsets leave the registers alone
    wr_reg(PSDO_OFS_STAT, 32'hFFFFFFFF);
    wr_reg(4'h2, 32'hFFFFFFFF, PSDO_RESP_SLVERR);
    rd_reg(4'h1, 32'h0, 32'hFFFFFFFF, PSDO_RESP_SLVERR);
    rd_reg(PSDO_OFS_DIR, {24'h0, d}, 32'hFFFFFFFF);
    rd_reg(PSDO_OFS_OUT, {24'h0, o}, 32'hFFFFFFFF);
    rd_reg(PSDO_OFS_CTRL, {21'h0, c}, 32'hFFFFFFFF);
    conclude();
  end
endmodule : psdo_top_tb
